// file: lsfd_pkg.sv
// constants and types shared by the led sink serial load and fault detect block
package lsfd_pkg;

  // ****************************************
  // channel and word sizes
  // ****************************************
  localparam int CH_COUNT = 16;
  localparam int CMD_LEN = 10;
  localparam logic SV_RESET = 1'b1;
  localparam int SV_BIT = 0;
  localparam int FLAG_ALARM_BIT = 9;
  localparam int FLAG_OVT_BIT = 8;
  localparam int FLAG_SHUT_BIT = 7;

  // ****************************************
  // strobe sequence counts
  // ****************************************
  localparam logic [2:0] CLKS_OPEN = 3'h1;
  localparam logic [2:0] CLKS_GND = 3'h2;
  localparam logic [2:0] CLKS_SHORT = 3'h3;
  localparam logic [2:0] CLKS_COMMAND = 3'h4;
  localparam logic [1:0] SMART_FALLS = 2'h2;

  // ****************************************
  // synchronised pin map
  // ****************************************
  localparam int PIN_SCLK = 0;
  localparam int PIN_SDI = 1;
  localparam int PIN_STB = 2;
  localparam int PIN_OEN = 3;
  localparam int PIN_ALARM = 4;
  localparam int PIN_OVT = 5;
  localparam int PIN_SHUT = 6;
  localparam int PIN_OPEN_BASE = 7;
  localparam int PIN_SHORT_BASE = PIN_OPEN_BASE + CH_COUNT;
  localparam int PIN_GND_BASE = PIN_SHORT_BASE + CH_COUNT;
  localparam int PIN_COUNT = PIN_GND_BASE + CH_COUNT;

  typedef enum logic [1:0] {
    MODE_IMAGE = 2'b00,
    MODE_COMMAND = 2'b01,
    MODE_SMART = 2'b10
  } lsfd_mode_t;

endpackage

// file: lsfd_sync_if.sv
// synchronised pin levels and edge pulses passed from the pin synchroniser to the core
interface lsfd_sync_if;
  import lsfd_pkg::*;
  logic [PIN_COUNT-1:0] level;
  logic [PIN_COUNT-1:0] rise;
  logic [PIN_COUNT-1:0] fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// file: lsfd_pin_sync.sv
// two-flop synchroniser with edge detection for every pin of the block
module lsfd_pin_sync
  import lsfd_pkg::*;
(
  input wire logic clk,
  input wire logic rstN,
  input wire logic [PIN_COUNT-1:0] pins,
  lsfd_sync_if.src sy
);

  typedef struct packed {
    logic [PIN_COUNT-1:0] meta;
    logic [PIN_COUNT-1:0] sync;
    logic [PIN_COUNT-1:0] prev;
    logic [PIN_COUNT-1:0] rise;
    logic [PIN_COUNT-1:0] fall;
  } lsfd_psync_t;

  lsfd_psync_t st;
  lsfd_psync_t next_st;

  // edges compare the second and third stage; the first stage feeds only the second
  always_comb begin
    next_st = st;
    next_st.meta = pins;
    next_st.sync = st.meta;
    next_st.prev = st.sync;
    for (int i = 0; i < PIN_COUNT; i++) begin
      next_st.rise[i] = st.sync[i] & ~st.prev[i];
      next_st.fall[i] = ~st.sync[i] & st.prev[i];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sy.level = st.prev;
  assign sy.rise = st.rise;
  assign sy.fall = st.fall;

endmodule

// file: lsfd_core.sv
// serial load, mode decode and fault detection logic of the 16-channel led sink driver
//
// Operation
// (R1) Shift serial input into the shift register on each serial clock rise.
// (R2) Strobe rising edge copies the shift register into the data latches.
// (R3) Image load mode uses a 16-bit register, one bit per channel.
// (R4) Command load mode uses a 10-bit shift register.
// (R5) Four clock rises with strobe high enter command mode at strobe fall.
// (R6) Ten clocks load the short level select bit; it resets to one.
// (R7) Latched image one turns a channel on, zero turns it off.
// (R8) Latched data changes only on a strobe rising edge.
// (R9) Controller raises strobe only after the last clock's falling edge.
// (R10) Level select picks the short threshold; one is the default level.
// (R11) Controller loads zeros into unused command bits.
// (R12) One clock rise with strobe high starts real-time open detection.
// (R13) Two clock rises with strobe high start real-time ground-short detection.
// (R14) Three clock rises with strobe high start real-time short detection.
// (R15) One clock rise then two strobe falls with clock high: smart open.
// (R16) Two clock rises then two strobe falls with clock high: smart ground-short.
// (R17) Three clock rises then two strobe falls with clock high: smart short.
// (R18) Detection results are loaded into the shift register for shifting out.
// (R19) Result bit is one for a fault, zero for a normal channel.
// (R20) Real-time open/short skip image-zero channels and disabled outputs, reporting zero.
// (R21) Real-time ground-short skips image-one channels, reporting zero.
// (R22) Real-time ground-short reports zero while the output enable is low.
// (R23) In latch-only operation the serial output carries the shifted-in data.
// (R24) Smart detection drives test current until next clock rise, ignoring enable; smart ground-short drives none.
// (R25) Command mode shifts out the thermal alarm, overtemp and shutdown flags.
// (R26) Comparator results are inputs sampled when the detection completes.
// (R27) After a detection the device returns to normal image load operation.
module lsfd_core
  import lsfd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serialClk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic outputEnableN,
  input wire logic thermal_alarm_flag,
  input wire logic overtemp_flag,
  input wire logic shutdownFlag,
  input wire logic [CH_COUNT-1:0] openFault,
  input wire logic [CH_COUNT-1:0] shortFault,
  input wire logic [CH_COUNT-1:0] gndFault,
  output logic serial_out,
  output logic [CH_COUNT-1:0] sink_channels,
  output logic testCurrentOn,
  output logic short_level_select,
  output logic command_load_mode
);

  // ****************************************
  // reset release
  // ****************************************
  logic [1:0] rstPipe;
  logic rstN;

  // assertion is immediate, release waits two clocks so all flops leave reset together
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end

  assign rstN = rstPipe[1];

  // ****************************************
  // pin synchronisation
  // ****************************************
  logic [PIN_COUNT-1:0] pins;
  lsfd_sync_if sy ();

  always_comb begin
    pins = '0;
    pins[PIN_SCLK] = serialClk;
    pins[PIN_SDI] = serial_in;
    pins[PIN_STB] = load_strobe;
    pins[PIN_OEN] = outputEnableN;
    pins[PIN_ALARM] = thermal_alarm_flag;
    pins[PIN_OVT] = overtemp_flag;
    pins[PIN_SHUT] = shutdownFlag;
    pins[PIN_OPEN_BASE +: CH_COUNT] = openFault;
    pins[PIN_SHORT_BASE +: CH_COUNT] = shortFault;
    pins[PIN_GND_BASE +: CH_COUNT] = gndFault;
  end

  // serial clock and data share one synchroniser so they stay aligned;
  // the serial clock must stay well below the core clock rate
  lsfd_pin_sync u_sync (
    .clk(core_clk),
    .rstN(rstN),
    .pins(pins),
    .sy(sy)
  );

  // ****************************************
  // detection decode
  // ****************************************
  // real-time masks follow the image and enable; smart detection ignores both
  function automatic logic [CH_COUNT-1:0] detect_result(
    input logic [2:0] kind,
    input logic realTime,
    input logic [CH_COUNT-1:0] image,
    input logic oeN,
    input logic [CH_COUNT-1:0] openCmp,
    input logic [CH_COUNT-1:0] shortCmp,
    input logic [CH_COUNT-1:0] gndCmp
  );
    logic [CH_COUNT-1:0] raw;
    logic [CH_COUNT-1:0] mask;
    raw = '0;
    mask = '1;
    case (kind)
      CLKS_OPEN: begin
        raw = openCmp; // [R12] [R15]
        if (realTime) begin
          mask = image & {CH_COUNT{~oeN}}; // [R20]
        end
      end
      CLKS_SHORT: begin
        raw = shortCmp; // [R14] [R17]
        if (realTime) begin
          mask = image & {CH_COUNT{~oeN}}; // [R20]
        end
      end
      CLKS_GND: begin
        raw = gndCmp; // [R13] [R16]
        if (realTime) begin
          mask = ~image & {CH_COUNT{oeN}}; // [R21] [R22]
        end
      end
      default: begin
        mask = '0;
      end
    endcase
    return raw & mask; // [R19]
  endfunction

  // ****************************************
  // core state
  // ****************************************
  typedef struct packed {
    lsfd_mode_t mode;
    logic [CH_COUNT-1:0] shiftReg;
    logic [CH_COUNT-1:0] imageLatch;
    logic [2:0] strobeClks;
    logic [1:0] smartFalls;
    logic [2:0] smartKind;
    logic shortLevel;
    logic serialOut;
    logic [CH_COUNT-1:0] sinkOn;
    logic testCurrent;
    logic commandMode;
  } lsfd_core_t;

  lsfd_core_t st;
  lsfd_core_t next_st;

  logic sclkRise;
  logic sclkHigh;
  logic sdi;
  logic stbRise;
  logic stbFall;
  logic stbHigh;
  logic oeN;
  logic shutdown;
  logic smartCandidate;
  logic [1:0] fallsNext;
  logic [CH_COUNT-1:0] openCmp;
  logic [CH_COUNT-1:0] shortCmp;
  logic [CH_COUNT-1:0] gndCmp;
  logic [CH_COUNT-1:0] flagWord;

  always_comb begin
    sclkRise = sy.rise[PIN_SCLK];
    sclkHigh = sy.level[PIN_SCLK];
    sdi = sy.level[PIN_SDI];
    stbRise = sy.rise[PIN_STB];
    stbFall = sy.fall[PIN_STB];
    stbHigh = sy.level[PIN_STB];
    oeN = sy.level[PIN_OEN];
    shutdown = sy.level[PIN_SHUT];
    openCmp = sy.level[PIN_OPEN_BASE +: CH_COUNT]; // [R26]
    shortCmp = sy.level[PIN_SHORT_BASE +: CH_COUNT]; // [R26]
    gndCmp = sy.level[PIN_GND_BASE +: CH_COUNT]; // [R26]
    flagWord = '0;
    flagWord[FLAG_ALARM_BIT] = sy.level[PIN_ALARM]; // [R25]
    flagWord[FLAG_OVT_BIT] = sy.level[PIN_OVT]; // [R25]
    flagWord[FLAG_SHUT_BIT] = shutdown; // [R25]
    smartCandidate = sclkHigh && (st.strobeClks >= CLKS_OPEN) && (st.strobeClks <= CLKS_SHORT);
    fallsNext = st.smartFalls + 2'h1;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_st = st;

    // ---- serial clock rising edge ----
    if (sclkRise) begin
      if (st.mode == MODE_SMART) begin
        // test window closes here: results replace the shift contents
        next_st.shiftReg = detect_result(st.smartKind, 1'b0, st.imageLatch, oeN,
                                         openCmp, shortCmp, gndCmp); // [R18] [R24] [R26]
        next_st.mode = MODE_IMAGE; // [R27]
      end else begin
        next_st.shiftReg = {st.shiftReg[CH_COUNT-2:0], sdi}; // [R1]
      end
      if (stbHigh && st.strobeClks != 3'h7) begin
        next_st.strobeClks = st.strobeClks + 3'h1;
      end
    end

    // ---- strobe rising edge ----
    if (stbRise) begin
      if (st.mode == MODE_COMMAND) begin
        // unused command bits are expected to be zero and are not stored
        next_st.shortLevel = st.shiftReg[SV_BIT]; // [R6] [R10] [R11]
        next_st.mode = MODE_IMAGE;
      end else begin
        next_st.imageLatch = st.shiftReg; // [R2] [R3] [R8] [R9]
      end
      // a smart sequence keeps its clock count across the second strobe pulse
      if (st.smartFalls == 2'h0) begin
        next_st.strobeClks = 3'h0;
      end
    end

    // ---- strobe falling edge ----
    if (stbFall) begin
      if (smartCandidate) begin
        if (fallsNext == SMART_FALLS) begin
          next_st.mode = MODE_SMART; // [R15] [R16] [R17]
          next_st.smartKind = st.strobeClks;
          next_st.smartFalls = 2'h0;
          next_st.strobeClks = 3'h0;
        end else begin
          next_st.smartFalls = fallsNext;
        end
      end else begin
        case (st.strobeClks)
          CLKS_COMMAND: begin
            next_st.mode = MODE_COMMAND; // [R5]
            next_st.shiftReg = flagWord; // [R25]
          end
          CLKS_OPEN, CLKS_GND, CLKS_SHORT: begin
            next_st.shiftReg = detect_result(st.strobeClks, 1'b1, st.imageLatch, oeN,
                                             openCmp, shortCmp, gndCmp); // [R12] [R13] [R14] [R18]
            next_st.mode = MODE_IMAGE; // [R27]
          end
          default: begin
          end
        endcase
        next_st.strobeClks = 3'h0;
        next_st.smartFalls = 2'h0;
      end
    end

    // ---- outputs ----
    if (next_st.mode == MODE_COMMAND) begin
      next_st.serialOut = next_st.shiftReg[CMD_LEN-1]; // [R4] [R25]
    end else begin
      next_st.serialOut = next_st.shiftReg[CH_COUNT-1]; // [R3] [R23]
    end

    if (shutdown) begin
      next_st.sinkOn = '0;
    end else if (next_st.mode == MODE_SMART) begin
      // ground-short test forces outputs off; open and short tests force all on
      next_st.sinkOn = (next_st.smartKind == CLKS_GND) ? '0 : '1; // [R24]
    end else begin
      next_st.sinkOn = next_st.imageLatch & {CH_COUNT{~oeN}}; // [R7]
    end
    next_st.testCurrent = (next_st.mode == MODE_SMART) && (next_st.smartKind != CLKS_GND); // [R24]
    next_st.commandMode = (next_st.mode == MODE_COMMAND);
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge core_clk or negedge rstN) begin
    if (!rstN) begin
      st <= '{mode: MODE_IMAGE, shortLevel: SV_RESET, default: '0}; // [R6] [R10]
    end else begin
      st <= next_st;
    end
  end

  assign serial_out = st.serialOut;
  assign sink_channels = st.sinkOn;
  assign testCurrentOn = st.testCurrent;
  assign short_level_select = st.shortLevel;
  assign command_load_mode = st.commandMode;

endmodule

// file: lsfd_core_props.sv
// assertion checker for the led sink serial load and fault detect core
module lsfd_core_props
  import lsfd_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serialClk,
  input wire logic load_strobe,
  input wire logic outputEnableN,
  input wire logic shutdownFlag,
  input wire logic thermal_alarm_flag,
  input wire logic serial_out,
  input wire logic [CH_COUNT-1:0] sink_channels,
  input wire logic testCurrentOn,
  input wire logic short_level_select,
  input wire logic command_load_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pinsQ;
  logic [3:0] quiet;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // cycles since any control pin moved; outputs lag pins by up to five clocks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pinsQ <= 4'h0;
      quiet <= 4'h0;
    end else begin
      pinsQ <= {serialClk, load_strobe, outputEnableN, shutdownFlag};
      quiet <= ({serialClk, load_strobe, outputEnableN, shutdownFlag} != pinsQ) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
    end
  end
  serial_hold_a: assert property (quiet > 4'h6 |-> $stable(serial_out) && $stable(command_load_mode))
    else $error("serial output moved with pins quiet");
  latch_hold_a: assert property (quiet > 4'h6 |-> $stable(sink_channels))
    else $error("channels moved with pins quiet");
  test_end_a: assert property ($rose(serialClk) && testCurrentOn |-> ##[1:6] !testCurrentOn)
    else $error("test current outlived clock rise");
  level_cause_a: assert property ($changed(short_level_select) |-> $past(command_load_mode))
    else $error("level select changed outside command mode");
  cmd_enter_a: assert property ($rose(command_load_mode) |-> $past(load_strobe, 7) && !$past(load_strobe, 3))
    else $error("command mode entered without strobe fall");
  cmd_exit_a: assert property ($fell(command_load_mode) |-> !$past(load_strobe, 7) && $past(load_strobe, 3))
    else $error("command mode left without strobe rise");
  alarm_first_a: assert property ($rose(command_load_mode) |-> serial_out == $past(thermal_alarm_flag, 6))
    else $error("alarm flag not first out in command mode");
  enable_off_a: assert property (outputEnableN [*8] ##0 !testCurrentOn |-> sink_channels == 16'h0000)
    else $error("channel on while outputs disabled");
endmodule

bind lsfd_core lsfd_core_props u_props (.core_clk(core_clk), .resetn(resetn), .serialClk(serialClk),
  .load_strobe(load_strobe), .outputEnableN(outputEnableN), .shutdownFlag(shutdownFlag),
  .thermal_alarm_flag(thermal_alarm_flag), .serial_out(serial_out), .sink_channels(sink_channels),
  .testCurrentOn(testCurrentOn), .short_level_select(short_level_select), .command_load_mode(command_load_mode));

// file: lsfd_ctrl_model.sv
// model of the display controller that drives the serial chain
module lsfd_ctrl_model
  import lsfd_pkg::*;
#(
  parameter int HOLD = 8
)
(
  input wire logic core_clk,
  input wire logic serial_out,
  output logic serialClk,
  output logic serial_in,
  output logic load_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    serialClk = 1'b0;
    serial_in = 1'b0;
    load_strobe = 1'b0;
  end
  // every pin level is held long enough for the core's oversampling
  task automatic settle();
    repeat (HOLD) @(negedge core_clk);
  endtask
  task automatic setClk(input logic v);
    serialClk = v;
    settle();
  endtask
  task automatic setStb(input logic v);
    load_strobe = v;
    settle();
  endtask
  task automatic pulse(input logic d, output logic q);
    serial_in = d;
    settle();
    q = serial_out;
    setClk(1'b1);
    serialClk = 1'b0; // strobe may only move after this fall
    serial_in = ~d;
    settle();
  endtask
  task automatic shift(input int n, input logic [CH_COUNT-1:0] din, output logic [CH_COUNT-1:0] dout);
    dout = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      pulse(din[i], dout[i]);
    end
  endtask
endmodule

// file: tb_led_sink_serial_load_and_fault_detect.sv
// self-checking bench for the led sink serial load and fault detect core
module tb_led_sink_serial_load_and_fault_detect
  import lsfd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic outputEnableN = 1'b0;
  logic thermal_alarm_flag = 1'b0;
  logic overtemp_flag = 1'b0;
  logic shutdownFlag = 1'b0;
  logic serialClk, serial_in, load_strobe, serial_out, testCurrentOn, short_level_select, command_load_mode;
  logic [CH_COUNT-1:0] openFault = 16'h0FF0;
  logic [CH_COUNT-1:0] shortFault = 16'h3C3C;
  logic [CH_COUNT-1:0] gndFault = 16'hF00F;
  logic [CH_COUNT-1:0] img = 16'hA5C3;
  logic [CH_COUNT-1:0] sink_channels, d;
  int fail_count = 0;
  int check_count = 0;

  initial forever #20 core_clk = ~core_clk;

  lsfd_core uut (.core_clk(core_clk), .resetn(resetn), .serialClk(serialClk), .serial_in(serial_in),
    .load_strobe(load_strobe), .outputEnableN(outputEnableN), .thermal_alarm_flag(thermal_alarm_flag),
    .overtemp_flag(overtemp_flag), .shutdownFlag(shutdownFlag), .openFault(openFault),
    .shortFault(shortFault), .gndFault(gndFault), .serial_out(serial_out), .sink_channels(sink_channels),
    .testCurrentOn(testCurrentOn), .short_level_select(short_level_select),
    .command_load_mode(command_load_mode));
  lsfd_ctrl_model #(.HOLD(8)) ctl (.core_clk(core_clk), .serial_out(serial_out), .serialClk(serialClk),
    .serial_in(serial_in), .load_strobe(load_strobe));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic check(input string what, input logic [CH_COUNT-1:0] got, input logic [CH_COUNT-1:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // smart results are not masked by image or enable, real-time ones are
  function automatic logic [CH_COUNT-1:0] expRes(input int k, input logic smart, input logic oeN);
    logic [CH_COUNT-1:0] on;
    on = {CH_COUNT{~oeN}};
    case (k)
      1: return smart ? openFault : openFault & img & on;
      2: return smart ? gndFault : gndFault & ~img & ~on;
      default: return smart ? shortFault : shortFault & img & on;
    endcase
  endfunction
  // load the image, then give k clocks under strobe; k of zero is a plain latch
  task automatic run(input int k, input logic smart);
    ctl.shift(CH_COUNT, img, d);
    ctl.setStb(1'b1);
    repeat (k - int'(smart)) ctl.pulse(1'b0, d[0]);
    if (smart) begin
      ctl.setClk(1'b1);
      ctl.setStb(1'b0);
      ctl.setStb(1'b1);
      ctl.setStb(1'b0);
      // the ground-short test turns every output off and runs no test current
      check("test current on", {15'h0000, testCurrentOn}, {15'h0000, k != 2});
      check("test sinks", sink_channels, (k == 2) ? 16'h0000 : 16'hFFFF);
      ctl.setClk(1'b0);
      ctl.setClk(1'b1);
      ctl.setClk(1'b0);
      check("test current off", {15'h0000, testCurrentOn}, 16'h0000);
    end else begin
      ctl.setStb(1'b0);
    end
    if (k > 0) begin
      ctl.shift(CH_COUNT, 16'h0000, d);
      check("fault report", d, expRes(k, smart, outputEnableN));
    end
  endtask

  initial begin
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    repeat (8) @(negedge core_clk);
    check("level select reset", {15'h0000, short_level_select}, {15'h0000, SV_RESET});
    check("mode after reset", {15'h0000, command_load_mode}, 16'h0000);
    run(0, 1'b0);
    check("latched image", sink_channels, img);
    ctl.shift(CH_COUNT, 16'h1234, d);
    check("latch holds", sink_channels, img);
    check("cascade data", d, img);
    for (int oe = 0; oe < 2; oe++) begin
      for (int k = 1; k < 4; k++) begin
        for (int s = 0; s < 2; s++) begin
          outputEnableN = oe[0];
          // comparator patterns move every run so each result depends on its own inputs
          openFault = {openFault[14:0], openFault[15]};
          shortFault = {shortFault[13:0], shortFault[15:14]};
          gndFault = {gndFault[12:0], gndFault[15:13]};
          run(k, s[0]);
        end
      end
    end
    outputEnableN = 1'b0;
    run(0, 1'b0);
    check("image after detection", sink_channels, img);
    for (int sv = 0; sv < 2; sv++) begin
      thermal_alarm_flag = ~sv[0];
      overtemp_flag = sv[0];
      shutdownFlag = 1'b1;
      // the strobe rise that opens the command sequence latches the shift register, so refill it
      ctl.shift(CH_COUNT, img, d);
      ctl.setStb(1'b1);
      repeat (CLKS_COMMAND) ctl.pulse(1'b0, d[0]);
      ctl.setStb(1'b0);
      check("command mode", {15'h0000, command_load_mode}, 16'h0001);
      check("shutdown sinks", sink_channels, 16'h0000);
      ctl.shift(CMD_LEN, {15'h0000, sv[0]}, d); // unused bits zero
      check("thermal flags", d & 16'h03FF, ({15'h0000, ~sv[0]} << FLAG_ALARM_BIT) |
        ({15'h0000, sv[0]} << FLAG_OVT_BIT) | (16'h0001 << FLAG_SHUT_BIT));
      ctl.setStb(1'b1);
      ctl.setStb(1'b0);
      shutdownFlag = 1'b0;
      repeat (8) @(negedge core_clk);
      check("level select", {15'h0000, short_level_select}, {15'h0000, sv[0]});
      check("mode exit", {15'h0000, command_load_mode}, 16'h0000);
      check("latch kept", sink_channels, img);
    end
    conclude();
  end

  initial begin
    repeat (60000) @(posedge core_clk);
    fail_count++;
    $display("[ERR] run length expected done seen timeout");
    conclude();
  end
endmodule
